// File: src/sfq_cmd_decode.sv
// Serial flash command front end: link decoder and core hand-off
`default_nettype none
// Behaviour
// RULE_01: Enter command switches to four-line mode for all phases.
// RULE_02: Four-line mode is 4-4-4 and leaves quad enable bit alone.
// RULE_03: Four-line mode uses all four lines for command, address, data.
// RULE_04: Only the exit command leaves four-line mode.
// RULE_05: After exit, commands are taken on one line again.
// RULE_06: Host keeps select high the minimum deselect time after mode change.
// RULE_07: Dummy cycles follow the two dummy select bits; host matches.
// RULE_08: Sector erase with three address bytes erases that sector.
// RULE_09: 64K block erase with three address bytes erases that block.
// RULE_10: Array reads, programs and erases decode by first opcode byte.
// RULE_11: Reads stream with incrementing address; programs take 1-256 bytes.
// RULE_12: Sample on rising clock edge, shift out on falling edge.
// RULE_13: Write-type commands ending off a byte boundary are discarded.
// RULE_14: Unknown command goes to standby, outputs floating, until next frame.
// RULE_15: Array access is ignored while an operation is in progress.
module sfq_cmd_decode (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  input wire logic dummy_select_low_i,
  input wire logic dummy_select_high_i,
  input wire logic busy_i,
  output logic four_line_command_mode_o,
  output logic cmd_valid_o,
  output sfq_pkg::sfq_cmd_t cmd_o,
  output logic prog_data_valid_o,
  output logic [7:0] prog_data_o,
  output logic array_rd_req_o,
  output logic [23:0] array_rd_addr_o,
  input wire logic [7:0] array_rd_data_i
);
  import sfq_pkg::*;

  //--------------------------------------------------------------
  // Opcode decode
  //--------------------------------------------------------------
  // Quad read dummy table by select code
  function automatic logic [3:0] qdummy(input logic [1:0] dc,
                                        input logic dtr);
    case (dc)
      DC_00: qdummy = DUMMY_6;
      DC_01: qdummy = dtr ? DUMMY_6 : DUMMY_4;
      DC_10: qdummy = DUMMY_8;
      default: qdummy = DUMMY_10;
    endcase
  endfunction : qdummy

  // First byte to command attributes in current mode
  function automatic sfq_dec_t decode(input logic [7:0] op,
                                      input logic quad,
                                      input logic [1:0] dc);
    sfq_dec_t d;
    d = '0;
    d.known = 1'b1;
    d.has_addr = 1'b1;
    d.addr_w = quad ? W4 : W1; // RULE_03
    d.data_w = quad ? W4 : W1;
    case (op) // RULE_10
      OP_READ: begin
        d.known = !quad;
        d.is_read = 1'b1;
      end
      OP_FAST, OP_2READ: begin
        d.known = !quad || (op == OP_FAST);
        d.is_read = 1'b1;
        d.dummy = (dc == DC_01) ? DUMMY_4 : DUMMY_8; // RULE_07
        if (op == OP_2READ) begin
          d.addr_w = W2;
          d.data_w = W2;
        end
      end
      OP_DREAD, OP_QREAD: begin
        d.known = !quad;
        d.is_read = 1'b1;
        d.dummy = DUMMY_8;
        d.data_w = (op == OP_QREAD) ? W4 : W2;
      end
      OP_4READ, OP_4DTRD, OP_W4READ: begin
        d.is_read = 1'b1;
        d.addr_w = W4;
        d.data_w = W4;
        d.dummy = qdummy(dc, op == OP_4DTRD); // RULE_07
        if (op == OP_W4READ) begin
          d.dummy = DUMMY_4;
        end
      end
      OP_PAGE_PROG, OP_QUAD_PROG: begin
        d.known = !quad || (op == OP_PAGE_PROG);
        d.is_prog = 1'b1;
        d.kind = KIND_PROG;
        if (op == OP_QUAD_PROG) begin
          d.addr_w = W4;
          d.data_w = W4;
        end
      end
      OP_SECTOR_ERASE: d.kind = KIND_SECTOR; // RULE_08
      OP_BLOCK32_ERASE: d.kind = KIND_BLOCK32;
      OP_BLOCK64_ERASE: d.kind = KIND_BLOCK64; // RULE_09
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
        d.kind = KIND_CHIP;
        d.has_addr = 1'b0;
      end
      OP_QUAD_ENTER, OP_QUAD_EXIT: begin
        d.known = quad == (op == OP_QUAD_EXIT);
        d.has_addr = 1'b0;
      end
      default: d.known = 1'b0; // RULE_14
    endcase
    decode = d;
  endfunction : decode

  //--------------------------------------------------------------
  // Link domain, rising serial clock
  //--------------------------------------------------------------
  sfq_state_t state_ff, nxt_state, st;
  sfq_dec_t dec_ff, nxt_dec, d;
  sfq_kind_t kind_ff, nxt_kind;
  logic started_ff, fresh, quad_ff, nxt_quad, quad;
  logic [4:0] cnt_ff, nxt_cnt, cnt, cnt_n;
  logic [11:0] bitcnt_ff, nxt_bitcnt, bits;
  logic [12:0] bsum;
  logic [23:0] sh_ff, sh_n, addr_ff, nxt_addr, rd_addr_ff, nxt_rd_addr;
  logic [7:0] op_ff, nxt_op, wbyte_ff, nxt_wbyte;
  logic rd_tgl_ff, nxt_rd_tgl, wr_tgl_ff, nxt_wr_tgl;
  logic [2:0] w;
  logic busy_s1_ff, busy_s2_ff;
  logic [1:0] dc_s1_ff, dc_s2_ff;
  logic [3:0] dwait_ff;
  logic [7:0] rd_word_ff;

  // Mode change of the previous frame is applied at the next first edge
  always_comb begin
    fresh = !started_ff;
    st = fresh ? ST_CMD : state_ff;
    cnt = fresh ? CNT_ZERO : cnt_ff;
    bits = fresh ? '0 : bitcnt_ff;
    quad = quad_ff;
    if (fresh && bitcnt_ff[2:0] == BIT_POS0 &&
        bitcnt_ff[11:3] == NB_ONE) begin
      if (op_ff == OP_QUAD_ENTER) begin
        quad = 1'b1; // RULE_01 RULE_02
      end else if (op_ff == OP_QUAD_EXIT) begin
        quad = 1'b0; // RULE_05
      end
    end
    case (st)
      ST_ADDR: w = dec_ff.addr_w;
      ST_DUMMY: w = W1;
      ST_RDATA, ST_WDATA: w = dec_ff.data_w;
      default: w = quad ? W4 : W1; // RULE_03
    endcase
    case (w)
      W4: sh_n = {sh_ff[19:0], io_i};
      W2: sh_n = {sh_ff[21:0], io_i[1:0]};
      default: sh_n = {sh_ff[22:0], io_i[0]};
    endcase
    cnt_n = cnt + {2'h0, w};
    bsum = {1'b0, bits} + {10'h000, w};
    d = decode(sh_n[7:0], quad, dc_s2_ff);
  end

  // Phase sequencing
  always_comb begin
    nxt_state = st;
    nxt_cnt = cnt_n;
    nxt_bitcnt = bsum[12] ? BITS_MAX : bsum[11:0];
    nxt_quad = quad;
    nxt_op = fresh ? '0 : op_ff;
    nxt_kind = fresh ? KIND_NONE : kind_ff;
    nxt_dec = dec_ff;
    nxt_addr = addr_ff;
    nxt_rd_addr = rd_addr_ff;
    nxt_rd_tgl = rd_tgl_ff;
    nxt_wr_tgl = wr_tgl_ff;
    nxt_wbyte = wbyte_ff;
    case (st)
      ST_CMD: if (cnt_n == CMD_BITS) begin
        nxt_op = sh_n[7:0];
        nxt_dec = d;
        nxt_cnt = CNT_ZERO;
        nxt_state = ST_STBY;
        if (d.known && !(d.is_read && busy_s2_ff)) begin // RULE_14 RULE_15
          nxt_kind = d.kind;
          if (d.has_addr) begin
            nxt_state = ST_ADDR;
          end
        end
      end
      ST_ADDR: if (cnt_n == ADDR_BITS) begin
        nxt_addr = sh_n;
        nxt_cnt = CNT_ZERO;
        nxt_state = dec_ff.is_prog ? ST_WDATA : ST_STBY;
        if (dec_ff.is_read) begin
          nxt_rd_addr = sh_n;
          nxt_rd_tgl = !rd_tgl_ff;
          nxt_state = (dec_ff.dummy == DUMMY_0) ? ST_RDATA : ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        nxt_bitcnt = bits;
        if (cnt_n == {1'b0, dec_ff.dummy}) begin // RULE_07
          nxt_cnt = CNT_ZERO;
          nxt_state = ST_RDATA;
        end
      end
      ST_RDATA: begin
        if (cnt == CNT_ZERO) begin
          nxt_rd_addr = rd_addr_ff + 24'h000001; // RULE_11
          nxt_rd_tgl = !rd_tgl_ff;
        end
        if (cnt_n == BYTE_BITS) begin
          nxt_cnt = CNT_ZERO;
        end
      end
      ST_WDATA: if (cnt_n == BYTE_BITS) begin
        nxt_cnt = CNT_ZERO;
        nxt_wbyte = sh_n[7:0]; // RULE_11
        nxt_wr_tgl = !wr_tgl_ff;
      end
      default: nxt_cnt = cnt;
    endcase
  end

  // Input sampling on the rising edge
  always_ff @(posedge sclk_i or posedge reset_i) begin // RULE_12
    if (reset_i) begin
      state_ff <= ST_STBY;
      cnt_ff <= CNT_ZERO;
      bitcnt_ff <= '0;
      sh_ff <= '0;
      op_ff <= '0;
      kind_ff <= KIND_NONE;
      dec_ff <= '0;
      addr_ff <= '0;
      rd_addr_ff <= '0;
      rd_tgl_ff <= 1'b0;
      wr_tgl_ff <= 1'b0;
      wbyte_ff <= '0;
      quad_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bitcnt_ff <= nxt_bitcnt;
      sh_ff <= sh_n;
      op_ff <= nxt_op;
      kind_ff <= nxt_kind;
      dec_ff <= nxt_dec;
      addr_ff <= nxt_addr;
      rd_addr_ff <= nxt_rd_addr;
      rd_tgl_ff <= nxt_rd_tgl;
      wr_tgl_ff <= nxt_wr_tgl;
      wbyte_ff <= nxt_wbyte;
      quad_ff <= nxt_quad;
    end
  end

  // Frame start flag, cleared whenever select is high
  always_ff @(posedge sclk_i or posedge reset_i or posedge cs_n_i) begin
    if (reset_i || cs_n_i) begin
      started_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
    end
  end

  // Core levels brought onto the link clock
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_s1_ff <= 1'b0;
      busy_s2_ff <= 1'b0;
      dc_s1_ff <= DC_00;
      dc_s2_ff <= DC_00;
      dwait_ff <= DUMMY_0;
    end else begin
      busy_s1_ff <= busy_i;
      busy_s2_ff <= busy_s1_ff;
      dc_s1_ff <= {dummy_select_high_i, dummy_select_low_i};
      dc_s2_ff <= dc_s1_ff;
      dwait_ff <= (started_ff && state_ff == ST_DUMMY) ?
                  dwait_ff + 4'h1 : DUMMY_0;
    end
  end

  //--------------------------------------------------------------
  // Link domain, falling serial clock output
  //--------------------------------------------------------------
  logic [7:0] out_ff, nxt_out;
  logic [3:0] nxt_oe_n, nxt_io;

  // Load a fresh byte at each byte start, else shift by width
  always_comb begin
    nxt_out = out_ff;
    nxt_oe_n = OE_OFF; // RULE_14
    if (started_ff && state_ff == ST_RDATA) begin
      if (cnt_ff == CNT_ZERO) begin
        nxt_out = rd_word_ff;
      end else begin
        case (dec_ff.data_w)
          W4: nxt_out = {out_ff[3:0], 4'h0};
          W2: nxt_out = {out_ff[5:0], 2'h0};
          default: nxt_out = {out_ff[6:0], 1'b0};
        endcase
      end
      case (dec_ff.data_w)
        W4: nxt_oe_n = OE_X4; // RULE_03
        W2: nxt_oe_n = OE_X2;
        default: nxt_oe_n = OE_X1;
      endcase
    end
    case (dec_ff.data_w)
      W4: nxt_io = nxt_out[7:4];
      W2: nxt_io = {2'h0, nxt_out[7:6]};
      default: nxt_io = {2'h0, nxt_out[7], 1'b0};
    endcase
  end

  // Output shifts on the falling edge, floats when deselected
  always_ff @(negedge sclk_i or posedge reset_i or posedge cs_n_i) begin
    if (reset_i || cs_n_i) begin
      out_ff <= '0;
      io_o <= '0;
      io_oe_n_o <= OE_OFF;
    end else begin
      out_ff <= nxt_out; // RULE_12
      io_o <= nxt_io;
      io_oe_n_o <= nxt_oe_n;
    end
  end

  //--------------------------------------------------------------
  // Core domain
  //--------------------------------------------------------------
  logic [2:0] cs_s_ff, rd_s_ff, wr_s_ff;
  logic frame_end, rec_bnd, issue_ok, rd_pend_ff;
  logic [8:0] rec_nb;

  // Synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cs_s_ff <= 3'h7;
      rd_s_ff <= 3'h0;
      wr_s_ff <= 3'h0;
    end else begin
      cs_s_ff <= {cs_s_ff[1:0], cs_n_i};
      rd_s_ff <= {rd_s_ff[1:0], rd_tgl_ff};
      wr_s_ff <= {wr_s_ff[1:0], wr_tgl_ff};
    end
  end

  // Frame record is still while select is high and the clock rests
  always_comb begin
    frame_end = cs_s_ff[1] && !cs_s_ff[2];
    rec_bnd = bitcnt_ff[2:0] == BIT_POS0; // RULE_13
    rec_nb = bitcnt_ff[11:3];
    case (kind_ff)
      KIND_SECTOR, KIND_BLOCK32, KIND_BLOCK64: issue_ok = rec_nb == NB_ERASE;
      KIND_CHIP: issue_ok = rec_nb == NB_ONE;
      KIND_PROG: issue_ok = rec_nb >= NB_PROG_MIN && rec_nb <= NB_PROG_MAX;
      default: issue_ok = 1'b0;
    endcase
    issue_ok = issue_ok && frame_end && rec_bnd && !busy_i; // RULE_15
  end

  // Program and erase hand-off at frame end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
    end else begin
      cmd_valid_o <= issue_ok; // RULE_08 RULE_09
      if (issue_ok) begin
        cmd_o <= '{kind: kind_ff, addr: addr_ff};
      end
    end
  end

  // Command mode flag, changed only by a clean one-byte frame
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      four_line_command_mode_o <= 1'b0;
    end else if (frame_end && rec_bnd && rec_nb == NB_ONE) begin
      if (op_ff == OP_QUAD_ENTER) begin
        four_line_command_mode_o <= 1'b1; // RULE_01
      end else if (op_ff == OP_QUAD_EXIT) begin
        four_line_command_mode_o <= 1'b0; // RULE_04
      end
    end
  end

  // Array read service and program byte delivery
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      array_rd_req_o <= 1'b0;
      array_rd_addr_o <= '0;
      rd_pend_ff <= 1'b0;
      rd_word_ff <= '0;
      prog_data_valid_o <= 1'b0;
      prog_data_o <= '0;
    end else begin
      array_rd_req_o <= rd_s_ff[1] ^ rd_s_ff[2];
      rd_pend_ff <= array_rd_req_o;
      if (rd_s_ff[1] ^ rd_s_ff[2]) begin
        array_rd_addr_o <= rd_addr_ff; // RULE_11
      end
      if (rd_pend_ff) begin
        rd_word_ff <= array_rd_data_i;
      end
      prog_data_valid_o <= wr_s_ff[1] ^ wr_s_ff[2];
      if (wr_s_ff[1] ^ wr_s_ff[2]) begin
        prog_data_o <= wbyte_ff;
      end
    end
  end

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  sequence seq_clean_byte(logic [7:0] opc);
    frame_end && rec_bnd && rec_nb == NB_ONE && op_ff == opc;
  endsequence

  chk_mode_enter: assert property ( // RULE_01
    @(posedge clock_i) disable iff (reset_i)
    seq_clean_byte(OP_QUAD_ENTER) |=> four_line_command_mode_o)
    else $error("enter frame did not set mode");
  chk_mode_exit: assert property ( // RULE_05
    @(posedge clock_i) disable iff (reset_i)
    seq_clean_byte(OP_QUAD_EXIT) |=> !four_line_command_mode_o[*2])
    else $error("exit frame did not clear mode");
  chk_mode_hold: assert property ( // RULE_04
    @(posedge clock_i) disable iff (reset_i)
    four_line_command_mode_o && !(frame_end && rec_bnd &&
    rec_nb == NB_ONE && op_ff == OP_QUAD_EXIT)
    |=> four_line_command_mode_o)
    else $error("mode left without exit");
  chk_sector_issue: assert property ( // RULE_08
    @(posedge clock_i) disable iff (reset_i)
    frame_end && rec_bnd && !busy_i && kind_ff == KIND_SECTOR &&
    rec_nb == NB_ERASE |=> cmd_valid_o && cmd_o.kind == KIND_SECTOR &&
    cmd_o.addr == $past(addr_ff))
    else $error("sector erase not issued");
  chk_block_issue: assert property ( // RULE_09
    @(posedge clock_i) disable iff (reset_i)
    frame_end && rec_bnd && !busy_i && kind_ff == KIND_BLOCK64 &&
    rec_nb == NB_ERASE |=> cmd_valid_o && cmd_o.kind == KIND_BLOCK64)
    else $error("block erase not issued");
  chk_busy_ignore: assert property ( // RULE_15
    @(posedge clock_i) disable iff (reset_i)
    busy_i |=> !cmd_valid_o)
    else $error("command issued while busy");
  chk_partial_drop: assert property ( // RULE_13
    @(posedge clock_i) disable iff (reset_i)
    frame_end && !rec_bnd |=> !cmd_valid_o && $stable(
    four_line_command_mode_o))
    else $error("off-boundary frame executed");
  chk_stby_float: assert property ( // RULE_14
    @(posedge sclk_i) disable iff (reset_i || cs_n_i)
    started_ff && $past(started_ff) && state_ff == ST_STBY &&
    $past(state_ff) == ST_STBY |-> io_oe_n_o == OE_OFF)
    else $error("standby drives outputs");
  chk_quad_drive: assert property ( // RULE_03
    @(posedge sclk_i) disable iff (reset_i || cs_n_i)
    started_ff && $past(started_ff) && state_ff == ST_RDATA &&
    $past(state_ff) == ST_RDATA && dec_ff.data_w == W4
    |-> io_oe_n_o == OE_X4)
    else $error("quad read not on four lines");
  chk_read_step: assert property ( // RULE_11
    @(posedge sclk_i) disable iff (reset_i || cs_n_i)
    started_ff && state_ff == ST_RDATA && cnt_ff == CNT_ZERO
    |=> rd_addr_ff == $past(rd_addr_ff) + 24'h000001)
    else $error("read address did not advance");
  chk_dummy_len: assert property ( // RULE_07
    @(posedge sclk_i) disable iff (reset_i || cs_n_i)
    started_ff && $past(started_ff) && state_ff == ST_RDATA &&
    $past(state_ff) == ST_DUMMY |-> dwait_ff == dec_ff.dummy)
    else $error("dummy count mismatch");
endmodule : sfq_cmd_decode
`default_nettype wire

// File: pkg/sfq_pkg.sv
// Shared constants and types of the serial flash command front end
`default_nettype none
package sfq_pkg;
  // Array and mode command opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_2READ = 8'hBB;
  localparam logic [7:0] OP_DREAD = 8'h3B;
  localparam logic [7:0] OP_4READ = 8'hEB;
  localparam logic [7:0] OP_W4READ = 8'hE7;
  localparam logic [7:0] OP_QREAD = 8'h6B;
  localparam logic [7:0] OP_4DTRD = 8'hED;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h38;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hF5;
  // Lines per serial clock
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;
  // Phase lengths in bits
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  // Dummy cycle counts and select codes
  localparam logic [3:0] DUMMY_0 = 4'h0;
  localparam logic [3:0] DUMMY_4 = 4'h4;
  localparam logic [3:0] DUMMY_6 = 4'h6;
  localparam logic [3:0] DUMMY_8 = 4'h8;
  localparam logic [3:0] DUMMY_10 = 4'hA;
  localparam logic [1:0] DC_00 = 2'h0;
  localparam logic [1:0] DC_01 = 2'h1;
  localparam logic [1:0] DC_10 = 2'h2;
  // Frame byte counts
  localparam logic [8:0] NB_ONE = 9'h001;
  localparam logic [8:0] NB_ERASE = 9'h004;
  localparam logic [8:0] NB_PROG_MIN = 9'h005;
  localparam logic [8:0] NB_PROG_MAX = 9'h104;
  localparam logic [11:0] BITS_MAX = 12'hFFF;
  localparam logic [2:0] BIT_POS0 = 3'h0;
  // Output enables, low drives the line
  localparam logic [3:0] OE_OFF = 4'hF;
  localparam logic [3:0] OE_X1 = 4'hD;
  localparam logic [3:0] OE_X2 = 4'hC;
  localparam logic [3:0] OE_X4 = 4'h0;
  typedef enum logic [2:0] {
    KIND_NONE = 3'h0, KIND_SECTOR = 3'h1, KIND_BLOCK32 = 3'h2,
    KIND_BLOCK64 = 3'h3, KIND_CHIP = 3'h4, KIND_PROG = 3'h5
  } sfq_kind_t;
  typedef enum logic [5:0] {
    ST_CMD = 6'h01, ST_ADDR = 6'h02, ST_DUMMY = 6'h04,
    ST_RDATA = 6'h08, ST_WDATA = 6'h10, ST_STBY = 6'h20
  } sfq_state_t;
  typedef struct packed {
    logic known;
    logic is_read;
    logic is_prog;
    logic has_addr;
    logic [2:0] addr_w;
    logic [2:0] data_w;
    logic [3:0] dummy;
    sfq_kind_t kind;
  } sfq_dec_t;
  typedef struct packed {
    sfq_kind_t kind;
    logic [23:0] addr;
  } sfq_cmd_t;
endpackage : sfq_pkg
`default_nettype wire

// File: sim/sfq_host.sv
// Host serial controller model that drives framed transfers
`default_nettype none
module sfq_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  input wire logic [3:0] io_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  // Idle state: clock parked low, select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
    rx = 8'h00;
  end
  // Shift nb bits out and clock nr cycles in, on four lines if w is 4, else on one line
  task automatic xfer(input logic [39:0] d, input int nb, input int w,
                      input int nr);
    #3 cs_n_o = 1'b0; // Keeps link edges off the core clock edges
    for (int i = 0; i < nb; i += w) begin
      io_o = (w == 4) ? d[39:36] : {~io_o[3:1], d[39]};
      d = d << w;
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    io_o = ~io_o;
    for (int i = 0; i < nr; i++) begin
      #80 sclk_o = 1'b1;
      rx = (w == 4) ? {rx[3:0], io_i} : {rx[6:0], io_i[1]};
      #80 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    io_o = ~io_o;
    #297;
  endtask : xfer
endmodule : sfq_host
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench of the serial flash command front end
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfq_pkg::*;
  logic clock_i, reset_i, dlo, dhi, busy, sclk, cs_n, four, cv, pv, rq;
  logic drove;
  logic [3:0] hio, dio, oe_n, io_w;
  sfq_cmd_t cmd;
  logic [7:0] pdat, b;
  logic [7:0] rdat = 8'h00;
  logic [23:0] raddr, a;
  logic [23:0] aq[$];
  int mismatches, compares, cvn, pvn;
  // Wire level: device drives where its enable is low, host elsewhere
  assign io_w = (oe_n & hio) | (~oe_n & dio);
  sfq_cmd_decode dut (.clock_i(clock_i), .reset_i(reset_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .io_i(io_w), .io_o(dio), .io_oe_n_o(oe_n),
    .dummy_select_low_i(dlo), .dummy_select_high_i(dhi), .busy_i(busy),
    .four_line_command_mode_o(four), .cmd_valid_o(cv), .cmd_o(cmd),
    .prog_data_valid_o(pv), .prog_data_o(pdat), .array_rd_req_o(rq),
    .array_rd_addr_o(raddr), .array_rd_data_i(rdat));
  sfq_host host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio), .io_i(io_w));
  // Expected array content at an address
  function automatic logic [7:0] exp_rd(input logic [23:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5A;
  endfunction : exp_rd
  // Array model and pulse monitors
  always @(posedge clock_i) begin
    if (rq === 1'b1) begin
      rdat <= exp_rd(raddr);
      aq.push_back(raddr);
    end
    if (cv === 1'b1) cvn++;
    if (pv === 1'b1) pvn++;
  end
  // Note whether any line was driven within a frame
  always @(posedge sclk) if (oe_n !== OE_OFF) drove = 1'b1;
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Write-type frame and its command hand-off
  task automatic erase(input logic [7:0] op, input logic [2:0] k,
                       input int nb, input int w, input int n);
    logic [23:0] ad;
    ad = 24'($urandom);
    cvn = 0;
    host.xfer({op, ad, 8'h00}, nb, w, 0);
    chk(32'(cvn), 32'(n));
    if (n == 1) begin
      chk(32'(cmd.kind), 32'(k));
      if (nb > 8) chk(32'(cmd.addr), 32'(ad));
    end
  endtask : erase
  // Read frame, checks first fetch and second streamed byte
  task automatic rd(input logic [7:0] op, input int dm, input int w,
                    input int ok);
    logic [23:0] ad;
    ad = 24'($urandom);
    aq.delete();
    drove = 1'b0;
    host.xfer({op, ad, 8'h00}, 32 + dm * w, w, 16 / w);
    chk(32'(drove), 32'(ok));
    chk(32'(oe_n), 32'(OE_OFF));
    if (ok == 1) begin
      chk(32'(aq[0]), 32'(ad));
      chk(32'(host.rx), 32'(exp_rd(ad + 24'h1)));
    end
  endtask : rd
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // Watchdog against a hung handshake
  initial begin
    #400us;
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    reset_i = 1'b1;
    busy = 1'b0;
    void'($urandom(54764));
    {dhi, dlo} = 2'($urandom);
    repeat (20) @(posedge clock_i);
    #1 reset_i = 1'b0;
    repeat (5) @(posedge clock_i);
    chk(32'(four), 32'h0);
    erase(OP_SECTOR_ERASE, KIND_SECTOR, 32, 1, 1);
    erase(OP_BLOCK64_ERASE, KIND_BLOCK64, 32, 1, 1);
    erase(OP_BLOCK32_ERASE, KIND_BLOCK32, 32, 1, 1);
    erase(OP_CHIP_ERASE_A, KIND_CHIP, 8, 1, 1);
    erase(OP_CHIP_ERASE_B, KIND_CHIP, 8, 1, 1);
    erase(OP_SECTOR_ERASE, KIND_SECTOR, 31, 1, 0);
    rd(OP_READ, 0, 1, 1);
    rd(OP_FAST, ({dhi, dlo} == DC_01) ? 4 : 8, 1, 1);
    rd(8'hFF, 0, 1, 0);
    a = 24'($urandom);
    b = 8'($urandom);
    cvn = 0;
    pvn = 0;
    host.xfer({OP_PAGE_PROG, a, b}, 40, 1, 0);
    chk(32'(cvn), 32'h1);
    chk(32'(pvn), 32'h1);
    chk(32'({cmd.kind, pdat}), 32'({KIND_PROG, b}));
    @(posedge clock_i) #1 busy = 1'b1;
    erase(OP_SECTOR_ERASE, KIND_SECTOR, 32, 1, 0);
    rd(OP_READ, 0, 1, 0);
    @(posedge clock_i) #1 busy = 1'b0;
    host.xfer({OP_QUAD_ENTER, 32'h0}, 8, 1, 0);
    chk(32'(four), 32'h1);
    erase(OP_SECTOR_ERASE, KIND_SECTOR, 32, 4, 1);
    rd(OP_FAST, ({dhi, dlo} == DC_01) ? 4 : 8, 4, 1);
    rd(OP_READ, 0, 4, 0);
    host.xfer({OP_QUAD_ENTER, 32'h0}, 8, 4, 0);
    chk(32'(four), 32'h1);
    host.xfer({OP_QUAD_EXIT, 32'h0}, 8, 4, 0);
    chk(32'(four), 32'h0);
    erase(OP_BLOCK64_ERASE, KIND_BLOCK64, 32, 1, 1);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
